//--- dcs_pkg.sv
package dcs_pkg;

  localparam int DATA_W = 14;
  localparam int AMP_W = 12;
  localparam int SCALE_W = 8;
  localparam int ADDR_W = 5;
  localparam int NUM_PROF = 4;

  // Register byte map: profile p occupies PROF_BASE + p * PROF_STRIDE
  localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] PROF_BASE = 5'h08;
  localparam logic [ADDR_W-1:0] PROF_STRIDE = 5'h06;
  localparam logic [ADDR_W-1:0] TUNE_B0_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] SCALE_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] FLAGS_OFS = 5'h05;
  localparam int FLAG_INVERT_BIT = 0;
  localparam int FLAG_CORR_EN_BIT = 1;

  localparam logic [7:0] SCALE_RST = 8'hB5;
  localparam logic [7:0] SCALE_UNITY = 8'h80;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int SCALE_FRAC = 7;

  // Inverse hold-envelope FIR taps, weights over 2^CORR_FRAC
  localparam logic signed [6:0] CORR_CENTER = 7'sh1D;
  localparam logic signed [6:0] CORR_SIDE = -7'sh04;
  localparam int CORR_FRAC = 5;
  localparam int MIX_SHIFT = 12;

  localparam logic signed [DATA_W-1:0] DAC_MAX = 14'sh1FFF;
  localparam logic signed [DATA_W-1:0] DAC_MIN = -14'sh2000;

  typedef struct packed {
    logic signed [DATA_W-1:0] i;
    logic signed [DATA_W-1:0] q;
  } dcs_iq_s;

endpackage

//--- dcs_iq_buf.sv
`timescale 1ns/10ps
module dcs_iq_buf (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input dcs_pkg::dcs_iq_s in_data,
  output logic out_valid,
  input wire logic out_ready,
  output dcs_pkg::dcs_iq_s out_data
);

  dcs_pkg::dcs_iq_s mem [0:1];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // dcs_iq_buf

//--- dcs_carrier_out.sv
`timescale 1ns/10ps
module dcs_carrier_out (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic [dcs_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [1:0] PROFILE,
  input wire logic IQ_VALID,
  output logic IQ_READY,
  input wire logic signed [dcs_pkg::DATA_W-1:0] IQ_I,
  input wire logic signed [dcs_pkg::DATA_W-1:0] IQ_Q,
  output logic signed [dcs_pkg::DATA_W-1:0] DAC_DATA
);

  localparam int NBYTE = 32;

  logic [7:0] regs_q [0:NBYTE-1];
  logic [1:0] prof_s1_q;
  logic [1:0] prof_s2_q;
  logic [1:0] prof_s3_q;
  logic [1:0] prof_q;
  logic [1:0] prof1_q;
  logic [1:0] prof2_q;
  logic [1:0] prof3_q;
  logic [31:0] tune_word [0:dcs_pkg::NUM_PROF-1];
  logic [7:0] scale_byte [0:dcs_pkg::NUM_PROF-1];
  logic [7:0] flag_byte [0:dcs_pkg::NUM_PROF-1];
  logic [31:0] phase_q;
  logic [7:0] rdata_q;
  logic buf_in_ready;
  logic buf_valid;
  dcs_pkg::dcs_iq_s buf_in;
  dcs_pkg::dcs_iq_s buf_out;
  logic in_ready_q;
  logic buf_push;

  logic signed [dcs_pkg::DATA_W-1:0] i1_q;
  logic signed [dcs_pkg::DATA_W-1:0] q1_q;
  logic signed [dcs_pkg::AMP_W-1:0] sin1_q;
  logic signed [dcs_pkg::AMP_W-1:0] cos1_q;
  logic inv1_q;
  logic signed [dcs_pkg::DATA_W-1:0] mix2_q;
  logic signed [dcs_pkg::DATA_W-1:0] tap_a_q;
  logic signed [dcs_pkg::DATA_W-1:0] tap_b_q;
  logic signed [dcs_pkg::DATA_W-1:0] corr3_q;
  logic signed [dcs_pkg::DATA_W-1:0] dac_q;
  logic corr_en;
  logic [7:0] scale;

  logic signed [25:0] prod_ic;
  logic signed [25:0] prod_qs;
  logic signed [26:0] mix_sum;
  logic signed [22:0] fir_sum;
  logic signed [22:0] fir_shift;
  logic signed [22:0] scl_prod;
  logic signed [22:0] scl_shift;

  function automatic logic [dcs_pkg::AMP_W-1:0] quarter(input logic [3:0] k);
    case (k)
      4'h0: quarter = 12'h064;
      4'h1: quarter = 12'h12C;
      4'h2: quarter = 12'h1F1;
      4'h3: quarter = 12'h2B2;
      4'h4: quarter = 12'h36B;
      4'h5: quarter = 12'h41C;
      4'h6: quarter = 12'h4C3;
      4'h7: quarter = 12'h55F;
      4'h8: quarter = 12'h5ED;
      4'h9: quarter = 12'h66C;
      4'hA: quarter = 12'h6DC;
      4'hB: quarter = 12'h73B;
      4'hC: quarter = 12'h787;
      4'hD: quarter = 12'h7C2;
      4'hE: quarter = 12'h7E9;
      default: quarter = 12'h7FD;
    endcase
  endfunction

  // Quarter-wave table folded by quadrant; half-step offset keeps symmetry
  function automatic logic signed [dcs_pkg::AMP_W-1:0] sine(input logic [5:0] ph);
    logic [dcs_pkg::AMP_W-1:0] mag;
    mag = ph[4] ? quarter(~ph[3:0]) : quarter(ph[3:0]);
    sine = ph[5] ? -$signed(mag) : $signed(mag);
  endfunction

  function automatic logic signed [dcs_pkg::DATA_W-1:0] sat14(input logic signed [22:0] v);
    if (v > 23'(dcs_pkg::DAC_MAX)) begin
      sat14 = dcs_pkg::DAC_MAX;
    end else if (v < 23'(dcs_pkg::DAC_MIN)) begin
      sat14 = dcs_pkg::DAC_MIN;
    end else begin
      sat14 = v[dcs_pkg::DATA_W-1:0];
    end
  endfunction

  function automatic logic is_scale_byte(input int a);
    logic hit;
    hit = 1'b0;
    for (int p = 0; p < dcs_pkg::NUM_PROF; p++) begin
      if (a == int'(dcs_pkg::PROF_BASE) + p * int'(dcs_pkg::PROF_STRIDE)
          + int'(dcs_pkg::SCALE_OFS)) begin
        hit = 1'b1;
      end
    end
    is_scale_byte = hit;
  endfunction

  // Control register bytes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int a = 0; a < NBYTE; a++) begin
        regs_q[a] <= is_scale_byte(a) ? dcs_pkg::SCALE_RST : dcs_pkg::BYTE_RST;
      end
    end else if (REG_WR && REG_ADDR >= dcs_pkg::PROF_BASE) begin
      regs_q[REG_ADDR] <= REG_WDATA;
    end
  end

  // Per-profile views of the byte map
  genvar gp;
  generate
    for (gp = 0; gp < dcs_pkg::NUM_PROF; gp++) begin : g_prof
      localparam int BASE = int'(dcs_pkg::PROF_BASE) + gp * int'(dcs_pkg::PROF_STRIDE);
      localparam int T0 = BASE + int'(dcs_pkg::TUNE_B0_OFS);
      // Profile 0 word in bytes 08h..0Bh, low byte at 08h
      assign tune_word[gp] = {regs_q[T0+3], regs_q[T0+2], regs_q[T0+1], regs_q[T0]};
      assign scale_byte[gp] = regs_q[BASE + int'(dcs_pkg::SCALE_OFS)];
      assign flag_byte[gp] = regs_q[BASE + int'(dcs_pkg::FLAGS_OFS)];
    end
  endgenerate

  // Read port: status byte shows active profile and input fullness
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
    end else if (REG_ADDR == dcs_pkg::STATUS_OFS) begin
      rdata_q <= {5'h00, ~buf_in_ready, prof_q};
    end else begin
      rdata_q <= regs_q[REG_ADDR];
    end
  end
  assign REG_RDATA = rdata_q;

  // Profile pins from outside; accept a change once stages two and three agree
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prof_s1_q <= 2'h0;
      prof_s2_q <= 2'h0;
      prof_s3_q <= 2'h0;
      prof_q <= 2'h0;
    end else begin
      prof_s1_q <= PROFILE;
      prof_s2_q <= prof_s1_q;
      prof_s3_q <= prof_s2_q;
      if (prof_s2_q == prof_s3_q) begin
        prof_q <= prof_s3_q;
      end
    end
  end

  // Profile follows its sample down the pipe; a switch never splits one word
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prof1_q <= 2'h0;
      prof2_q <= 2'h0;
      prof3_q <= 2'h0;
    end else begin
      prof1_q <= prof_q;
      prof2_q <= prof1_q;
      prof3_q <= prof2_q;
    end
  end

  // Correction and scale use the profile of the word now in their stage
  assign corr_en = flag_byte[prof2_q][dcs_pkg::FLAG_CORR_EN_BIT];
  assign scale = scale_byte[prof3_q];

  // Words above 2^31-1 are outside the legal range; top bit is ignored
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_q <= 32'h0000_0000;
    end else begin
      phase_q <= phase_q + {1'b0, tune_word[prof_q][30:0]};
    end
  end

  // Two-entry input buffer; drained once per clock, source stalls when full
  assign buf_in.i = IQ_I;
  assign buf_in.q = IQ_Q;
  // Only words seen with ready high are taken, so a held word is never doubled
  assign buf_push = IQ_VALID && in_ready_q;
  dcs_iq_buf dcs_iq_buf_i (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(buf_in),
    .out_valid(buf_valid),
    .out_ready(1'b1),
    .out_data(buf_out)
  );

  // Ready is registered, so it reflects last cycle's room; buffer absorbs the slip
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      in_ready_q <= 1'b0;
    end else begin
      in_ready_q <= buf_in_ready;
    end
  end
  assign IQ_READY = in_ready_q;

  // Stage 1: carrier lookup and sample capture; empty buffer yields silence
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      i1_q <= '0;
      q1_q <= '0;
      sin1_q <= '0;
      cos1_q <= '0;
      inv1_q <= 1'b0;
    end else begin
      i1_q <= buf_valid ? buf_out.i : '0;
      q1_q <= buf_valid ? buf_out.q : '0;
      sin1_q <= sine(phase_q[31:26]);
      cos1_q <= sine(phase_q[31:26] + 6'h10);
      inv1_q <= flag_byte[prof_q][dcs_pkg::FLAG_INVERT_BIT];
    end
  end

  assign prod_ic = i1_q * cos1_q;
  assign prod_qs = q1_q * sin1_q;
  assign mix_sum = inv1_q ? (27'(prod_ic) + 27'(prod_qs))
                          : (27'(prod_ic) - 27'(prod_qs));

  // Stage 2: modulate; the shift halves the amplitude, a 6 dB modulator loss
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mix2_q <= '0;
    end else begin
      mix2_q <= sat14(23'(mix_sum >>> dcs_pkg::MIX_SHIFT));
    end
  end

  // Taps -4/32, 29/32, -4/32: DC gain 21/32, about -3.7 dB, rising toward 0.45 fs
  assign fir_sum = 23'(dcs_pkg::CORR_SIDE) * 23'(tap_a_q)
                 + 23'(dcs_pkg::CORR_CENTER) * 23'(tap_b_q)
                 + 23'(dcs_pkg::CORR_SIDE) * 23'(mix2_q);
  assign fir_shift = fir_sum >>> dcs_pkg::CORR_FRAC;

  // Delay line frozen when bypassed, standing in for a stopped clock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tap_a_q <= '0;
      tap_b_q <= '0;
    end else if (corr_en) begin
      tap_a_q <= tap_b_q;
      tap_b_q <= mix2_q;
    end
  end

  // Stage 3: corrected or routed around
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      corr3_q <= '0;
    end else begin
      corr3_q <= corr_en ? sat14(fir_shift) : mix2_q;
    end
  end

  assign scl_prod = 23'(corr3_q) * $signed({15'h0000, scale});
  assign scl_shift = scl_prod >>> dcs_pkg::SCALE_FRAC;

  // Stage 4: output scale; unity passes straight through
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dac_q <= '0;
    end else if (scale == dcs_pkg::SCALE_UNITY) begin
      dac_q <= corr3_q;
    end else begin
      dac_q <= sat14(scl_shift);
    end
  end

  assign DAC_DATA = dac_q;

endmodule // dcs_carrier_out

//--- dcs_chk_assertions.sv
`timescale 1ns/10ps
module dcs_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic [dcs_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic [1:0] PROFILE,
  input wire logic IQ_VALID,
  input wire logic IQ_READY,
  input wire logic signed [dcs_pkg::DATA_W-1:0] IQ_I,
  input wire logic signed [dcs_pkg::DATA_W-1:0] IQ_Q,
  input wire logic signed [dcs_pkg::DATA_W-1:0] DAC_DATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_fresh;
    $rose(RST_N) && !REG_WR && REG_ADDR == 5'h0C;
  endsequence
  sequence s_wr;
    (REG_WR && REG_ADDR >= 5'h08) ##1 (!REG_WR && $stable(REG_ADDR));
  endsequence
  sequence s_hold;
    (REG_ADDR >= 5'h08 && $stable(REG_ADDR) && !REG_WR)[*3];
  endsequence
  sequence s_stat;
    (REG_ADDR == 5'h00 && $stable(PROFILE))[*5];
  endsequence
  // Long enough for pipeline and profile sync to flush
  sequence s_idle;
    (!IQ_VALID && !REG_WR && $stable(PROFILE))[*8];
  endsequence
  property p_rst_out;
    $rose(RST_N) |-> DAC_DATA == 14'h0000 && REG_RDATA == 8'h00 && !IQ_READY;
  endproperty
  property p_rdy_up;
    $rose(RST_N) |=> IQ_READY;
  endproperty
  property p_rdy_keep;
    $past(RST_N) |-> IQ_READY;
  endproperty
  property p_wr_rd;
    s_wr |=> REG_RDATA == $past(REG_WDATA, 2);
  endproperty
  property p_rd_stands;
    s_hold |-> $stable(REG_RDATA);
  endproperty
  property p_status;
    s_stat |-> REG_RDATA == {6'h00, PROFILE};
  endproperty
  property p_idle_zero;
    s_idle |-> ##3 DAC_DATA == 14'h0000;
  endproperty
  property p_scale_rst;
    s_fresh |=> REG_RDATA == 8'hB5;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not cleared by reset");
  a_rdy_up: assert property (p_rdy_up)
    else $error("sample input not ready after reset");
  a_rdy_keep: assert property (p_rdy_keep)
    else $error("sample input stalled");
  a_wr_rd: assert property (p_wr_rd)
    else $error("written byte not read back");
  a_rd_stands: assert property (p_rd_stands)
    else $error("read data moved without cause");
  a_status: assert property (p_status)
    else $error("status byte wrong");
  a_idle_zero: assert property (p_idle_zero)
    else $error("missing samples not zero");
  a_scale_rst: assert property (p_scale_rst)
    else $error("scale reset value wrong");
endmodule // dcs_chk

bind dcs_carrier_out dcs_chk dcs_chk_i (.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .PROFILE(PROFILE),
  .IQ_VALID(IQ_VALID), .IQ_READY(IQ_READY), .IQ_I(IQ_I), .IQ_Q(IQ_Q), .DAC_DATA(DAC_DATA));

//--- dcs_dac_model.sv
`timescale 1ns/10ps
module dcs_dac_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [dcs_pkg::DATA_W-1:0] code,
  output logic signed [dcs_pkg::DATA_W-1:0] conv_q
);
  // Converter takes a word every clock, no way to stall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_q <= '0;
    end else begin
      conv_q <= code;
    end
  end
endmodule // dcs_dac_model

//--- test_dcs_carrier_out.sv
`timescale 1ns/10ps
module test_dcs_carrier_out;
  logic CLK, RST_N, REG_WR, IQ_VALID, IQ_READY;
  logic [4:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA;
  logic [1:0] PROFILE;
  logic signed [13:0] IQ_I, IQ_Q, DAC_DATA, conv;
  int num_errors = 0;
  int n_tests = 0;
  logic [31:0] word = 32'h556AAAAB;

  dcs_carrier_out dcs_carrier_out_i (.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .PROFILE(PROFILE),
    .IQ_VALID(IQ_VALID), .IQ_READY(IQ_READY), .IQ_I(IQ_I), .IQ_Q(IQ_Q), .DAC_DATA(DAC_DATA));
  dcs_dac_model dcs_dac_model_i (.clk(CLK), .rst_n(RST_N), .code(DAC_DATA), .conv_q(conv));

  always #12.5 CLK = ~CLK;

  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Strobe left high so back-to-back writes never re-drive it in one step
  task wr(input logic [4:0] a, input logic [7:0] d);
    REG_WR = 1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(posedge CLK);
    #2;
  endtask
  task idle(input int n);
    REG_WR = 0;
    repeat (n) @(posedge CLK);
    #2;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    REG_ADDR = a;
    idle(2);
    chk({8'h00, REG_RDATA}, {8'h00, e});
  endtask
  // Covers pipeline plus profile sync
  task dac(input int e);
    idle(14);
    chk(16'(conv), 16'(e));
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    finish_test;
  end

  initial begin
    CLK = 0; RST_N = 0; REG_WR = 0; REG_ADDR = 5'h0C; REG_WDATA = 8'h00;
    PROFILE = 2'h0; IQ_VALID = 0; IQ_I = '0; IQ_Q = '0;
    repeat (4) @(posedge CLK);
    #2 RST_N = 1;
    idle(2);
    rd(5'h0C, 8'hB5);
    rd(5'h12, 8'hB5);
    rd(5'h08, 8'h00);
    rd(5'h00, 8'h00);
    idle(5);
    $display("test reset done");
    IQ_VALID = 1;
    IQ_I = 14'sh03E8;
    dac(705);
    wr(5'h0C, 8'h80);
    dac(499);
    wr(5'h0C, 8'h00);
    dac(0);
    wr(5'h0C, 8'h80);
    wr(5'h0D, 8'h02);
    dac(327);
    wr(5'h0D, 8'h00);
    wr(5'h12, 8'hFF);
    PROFILE = 2'h1;
    dac(994);
    // Status must show the new profile for long enough to be checked
    rd(5'h00, 8'h01);
    idle(3);
    PROFILE = 2'h0;
    wr(5'h0B, 8'h80);
    wr(5'h0A, 8'h00);
    wr(5'h09, 8'h00);
    wr(5'h08, 8'h00);
    dac(499);
    $display("test scale done");
    IQ_I = '0;
    IQ_Q = 14'sh03E8;
    // Word held one clock: phase steps a quarter turn and stops
    wr(5'h0B, 8'h40);
    wr(5'h0B, 8'h00);
    dac(-500);
    wr(5'h0D, 8'h01);
    dac(499);
    // Past full scale both ways: clipped, never wrapped
    IQ_I = 14'sh2000;
    IQ_Q = 14'sh1FFF;
    wr(5'h0C, 8'hFF);
    dac(8191);
    IQ_I = 14'sh1FFF;
    IQ_Q = 14'sh2000;
    dac(-8192);
    for (int k = 0; k < 4; k++) wr(5'h08 + 5'(k), word[8*k +: 8]);
    for (int k = 0; k < 4; k++) rd(5'h08 + 5'(k), word[8*k +: 8]);
    $display("test carrier done");
    IQ_VALID = 0;
    dac(0);
    $display("test idle done");
    finish_test;
  end
endmodule // test_dcs_carrier_out
